/* rtl/hbta_core.sv */
// host bus transaction attribute logic: tags, claims, errors, cfg bits
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "hbta_defs.svh"
module hbta_core #(
   parameter int BAR_MASK_BITS = 12  // window size, log2 bytes
) (
   input  wire logic                   clk,              // host bus clock
   input  wire logic                   reset,            // ordinary reset
   input  wire logic                   main_power_good_reset, // sticky rw
   input  wire logic                   aux_power_ok_reset,    // sticky w1c
   input  wire logic                   aux_power_enabled, // aux power use
   // register port
   input  wire logic [7:0]             reg_addr,         // byte address
   input  wire logic [31:0]            reg_wdata,        // write data
   input  wire logic                   reg_wr,           // write strobe
   input  wire logic                   reg_rd,           // read strobe
   output logic      [31:0]            reg_rdata,        // read data
   // client request side
   input  wire logic                   req_valid,        // client request
   input  wire hbta_pkg::hbta_client_type req_client,    // requesting client
   input  wire logic [1:0]             req_slot,         // tx data slot
   output logic                        req_issue,        // request sent
   output logic      [7:0]             req_tag,          // header tag
   output logic      [15:0]            req_id,           // requester id
   // incoming cycles from host
   input  wire logic                   in_valid,         // cycle present
   input  wire hbta_pkg::hbta_in_kind_type in_kind,      // cycle kind
   input  wire logic                   in_parity_err,    // forwarded perr
   input  wire logic [31:0]            in_addr,          // address
   input  wire logic [7:0]             in_cfg_bus,       // cfg bus number
   input  wire logic [4:0]             in_cfg_dev,       // cfg device
   input  wire logic [2:0]             in_cfg_func,      // cfg function
   input  wire logic                   in_cfg_type0,     // cfg type 0
   input  wire logic [7:0]             in_tag,           // completion tag
   input  wire logic [2:0]             in_cpl_status,    // completion status
   output logic                        claim,            // cycle claimed
   output logic      [15:0]            cpl_id,           // completer id
   output logic                        cpl_deliver,      // good completion
   output logic      [7:0]             cpl_tag,          // routed tag
   output logic                        serr_pulse        // system error
);
   initial begin
      if (BAR_MASK_BITS < 4 || BAR_MASK_BITS > 31)
         $error("BAR_MASK_BITS out of range");
   end

   logic [15:0] cmd_ff;        // command bits
   logic        perr_ff;       // parity error status
   logic        serr_ff;       // system error status
   logic [7:0]  bus_ff;        // captured bus number
   logic [31:0] bar_mem_ff;    // memory window base
   logic [31:0] bar_io_ff;     // io window base
   logic [15:0] sticky_ff;     // sticky rw bits
   logic [15:0] stk_stat_ff;   // sticky w1c bits
   logic [15:0] wonce_ff;      // write-once field
   logic        wonce_lock_ff; // write-once locked
   logic [15:0] my_id;         // bus/dev/func identifier
   logic        wr_cmd;        // write to command
   logic        wr_stat;       // write to status
   logic        cfg_hit;       // own type 0 config cycle
   logic        mem_hit;       // memory window hit
   logic        io_hit;        // io window hit
   logic        in_good;       // cycle without parity error
   logic        cpl_bad;       // unsuccessful completion
   logic [7:0]  nxt_tag;       // tag for current client
   logic        master_ok;     // request allowed
   logic        stk_event;     // sticky status event
   logic        sticky_rst;    // gated sticky rw reset

   assign my_id   = {bus_ff, `HBTA_DEV_NUM, `HBTA_FUNC_NUM};
   // register write decode
   assign wr_cmd  = reg_wr && reg_addr == `HBTA_OFF_CMD;
   assign wr_stat = reg_wr && reg_addr == `HBTA_OFF_STAT;
   // parity-marked cycles are never acted on
   assign in_good = in_valid && !in_parity_err;
   // own config cycle: device and function match, type 0
   assign cfg_hit = in_good && in_cfg_type0 &&
      (in_kind == hbta_pkg::HBTA_IN_CFG_RD ||
       in_kind == hbta_pkg::HBTA_IN_CFG_WR) &&
      in_cfg_dev == `HBTA_DEV_NUM && in_cfg_func == `HBTA_FUNC_NUM;
   // window compares on the upper address bits
   assign mem_hit = in_good && cmd_ff[`HBTA_CMD_MEM] &&
      (in_kind == hbta_pkg::HBTA_IN_MEM_RD ||
       in_kind == hbta_pkg::HBTA_IN_MEM_WR) &&
      in_addr[31:BAR_MASK_BITS] == bar_mem_ff[31:BAR_MASK_BITS];
   assign io_hit  = in_good && cmd_ff[`HBTA_CMD_IO] &&
      (in_kind == hbta_pkg::HBTA_IN_IO_RD ||
       in_kind == hbta_pkg::HBTA_IN_IO_WR) &&
      in_addr[31:BAR_MASK_BITS] == bar_io_ff[31:BAR_MASK_BITS];
   // completion with a failing status
   assign cpl_bad = in_good && in_kind == hbta_pkg::HBTA_IN_CPL &&
      in_cpl_status != `HBTA_CPL_OK;
   // sticky status source
   assign stk_event = perr_ff; // sticky status set while the parity error flag is set

   // client to tag map; only listed codes are produced
   always_comb begin
      nxt_tag = `HBTA_TAG_MSI;
      unique case (req_client)
         hbta_pkg::HBTA_CL_RX_DATA: nxt_tag = `HBTA_TAG_RX_DATA;
         hbta_pkg::HBTA_CL_RX_DRD0: nxt_tag = `HBTA_TAG_RX_DRD0;
         hbta_pkg::HBTA_CL_RX_DWB0: nxt_tag = `HBTA_TAG_RX_DWB0;
         hbta_pkg::HBTA_CL_RX_DRD1: nxt_tag = `HBTA_TAG_RX_DRD1;
         hbta_pkg::HBTA_CL_RX_DWB1: nxt_tag = `HBTA_TAG_RX_DWB1;
         hbta_pkg::HBTA_CL_TX_DRD0: nxt_tag = `HBTA_TAG_TX_DRD0;
         hbta_pkg::HBTA_CL_TX_DWB0: nxt_tag = `HBTA_TAG_TX_DWB0;
         hbta_pkg::HBTA_CL_TX_DRD1: nxt_tag = `HBTA_TAG_TX_DRD1;
         hbta_pkg::HBTA_CL_TX_DWB1: nxt_tag = `HBTA_TAG_TX_DWB1;
         hbta_pkg::HBTA_CL_TX_DATA:
            nxt_tag = `HBTA_TAG_TX_DAT0 | {6'h00, req_slot};
         hbta_pkg::HBTA_CL_MNG_RD:  nxt_tag = `HBTA_TAG_MNG_RD;
         hbta_pkg::HBTA_CL_MNG_WR:  nxt_tag = `HBTA_TAG_MNG_WR;
         hbta_pkg::HBTA_CL_MSI:     nxt_tag = `HBTA_TAG_MSI;
         default:                   nxt_tag = `HBTA_TAG_MSI;
      endcase
   end

   // memory requests need master enable; messages do not
   assign master_ok = req_client == hbta_pkg::HBTA_CL_MSI ||
      cmd_ff[`HBTA_CMD_MASTER];

   // request issue: tag and identifier stamped on each request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         req_issue <= 1'b0;
         req_tag   <= 8'h00;
         req_id    <= 16'h0000;
      end else begin
         // one pulse per accepted request
         req_issue <= req_valid && master_ok;
         if (req_valid && master_ok) begin
            req_tag <= nxt_tag;
            req_id  <= my_id;
         end
      end
   end

   // claims and completer identity
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         claim  <= 1'b0;
         cpl_id <= 16'h0000;
      end else begin
         claim <= cfg_hit || mem_hit || io_hit;
         // a capturing write answers with the new bus number
         if (cfg_hit && in_kind == hbta_pkg::HBTA_IN_CFG_WR)
            cpl_id <= {in_cfg_bus, `HBTA_DEV_NUM, `HBTA_FUNC_NUM};
         else if (cfg_hit || mem_hit || io_hit)
            cpl_id <= my_id;
      end
   end

   // incoming completions: good ones routed by tag, in arrival order;
   // no timer watches outstanding requests
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpl_deliver <= 1'b0;
         cpl_tag     <= 8'h00;
      end else begin
         cpl_deliver <= in_good && in_kind == hbta_pkg::HBTA_IN_CPL &&
            in_cpl_status == `HBTA_CPL_OK;
         if (in_good && in_kind == hbta_pkg::HBTA_IN_CPL)
            cpl_tag <= in_tag;
      end
   end

   // bus number captured from own config writes
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         bus_ff <= 8'h00;
      else if (cfg_hit && in_kind == hbta_pkg::HBTA_IN_CFG_WR)
         bus_ff <= in_cfg_bus;
   end

   // command register: only implemented bits writable
   // reserved bits read back as zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         cmd_ff <= 16'h0000;
      else if (wr_cmd)
         cmd_ff <= reg_wdata[15:0] & 16'h0547;
   end

   // window bases
   // low address bits are not compared
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bar_mem_ff <= 32'h0000_0000;
         bar_io_ff  <= 32'h0000_0000;
      end else begin
         if (reg_wr && reg_addr == `HBTA_OFF_BAR_MEM)
            bar_mem_ff <= reg_wdata;
         if (reg_wr && reg_addr == `HBTA_OFF_BAR_IO)
            bar_io_ff <= reg_wdata;
      end
   end

   // error flags: set wins over a write-one clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         perr_ff <= 1'b0;
         serr_ff <= 1'b0;
      end else begin
         // parity error flag
         if (in_valid && in_parity_err)
            perr_ff <= 1'b1;
         else if (wr_stat && reg_wdata[`HBTA_ST_PERR])
            perr_ff <= 1'b0;
         // system error flag
         if (cpl_bad)
            serr_ff <= 1'b1;
         else if (wr_stat && reg_wdata[`HBTA_ST_SERR])
            serr_ff <= 1'b0;
      end
   end

   // system error signal toward the chipset
   // one pulse per event whose command enable bit is set; the flags stay for software
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         serr_pulse <= 1'b0;
      else
         serr_pulse <= (in_valid && in_parity_err &&
                        cmd_ff[`HBTA_CMD_PERR]) ||
                       (cpl_bad && cmd_ff[`HBTA_CMD_SERR]);
   end

   // gated reset: the aux level must stay steady while power good
   // is raised, or a glitch on it could clear the bits
   assign sticky_rst = main_power_good_reset && !aux_power_enabled;
   // sticky rw bits: only power good, held while aux power in use
   always_ff @(posedge clk or posedge sticky_rst) begin
      if (sticky_rst)
         sticky_ff <= `HBTA_STICKY_RST;
      else if (reg_wr && reg_addr == `HBTA_OFF_STICKY)
         sticky_ff <= reg_wdata[15:0];
   end

   // sticky w1c status: only aux ok; bit 0 records parity events
   // hardware set wins over a write-one clear
   always_ff @(posedge clk or posedge aux_power_ok_reset) begin
      if (aux_power_ok_reset)
         stk_stat_ff <= 16'h0000;
      else if (stk_event)
         stk_stat_ff <= stk_stat_ff | 16'h0001;
      else if (reg_wr && reg_addr == `HBTA_OFF_STKSTAT)
         stk_stat_ff <= stk_stat_ff & ~reg_wdata[15:0];
   end

   // write-once field
   // lock holds until ordinary reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wonce_ff      <= `HBTA_WONCE_RST;
         wonce_lock_ff <= 1'b0;
      end else if (reg_wr && reg_addr == `HBTA_OFF_WONCE &&
                   !wonce_lock_ff) begin
         wonce_ff      <= reg_wdata[15:0];
         wonce_lock_ff <= 1'b1;
      end
   end

   // read data, one cycle after the strobe
   // unmapped addresses read as zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         reg_rdata <= 32'h0000_0000;
      else if (!reg_rd)
         reg_rdata <= 32'h0000_0000;
      else begin
         unique case (reg_addr)
            `HBTA_OFF_CMD:     reg_rdata <= {16'h0000, cmd_ff};
            // status: flags on top, bit 4 reads one
            `HBTA_OFF_STAT:    reg_rdata <= {16'h0000, perr_ff, serr_ff,
                                             14'h0010};
            `HBTA_OFF_ID:      reg_rdata <= {16'h0000, my_id};
            `HBTA_OFF_BAR_MEM: reg_rdata <= bar_mem_ff;
            `HBTA_OFF_BAR_IO:  reg_rdata <= bar_io_ff;
            `HBTA_OFF_STICKY:  reg_rdata <= {16'h0000, sticky_ff};
            `HBTA_OFF_STKSTAT: reg_rdata <= {16'h0000, stk_stat_ff};
            `HBTA_OFF_WONCE:   reg_rdata <= {16'h0000, wonce_ff};
            default:           reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // assertions
   // tag checks
   tag_issue_a: assert property (@(posedge clk) disable iff (reset)
      req_valid && master_ok |=> req_issue && req_tag == $past(nxt_tag))
      else $error("request tag wrong");
   tag_legal_a: assert property (@(posedge clk) disable iff (reset)
      req_issue |-> req_tag inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h05,
         8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0e,
         8'h10, 8'h11, 8'h1e})
      else $error("illegal tag issued");
   // master enable gate
   master_gate_a: assert property (@(posedge clk) disable iff (reset)
      req_valid && !cmd_ff[`HBTA_CMD_MASTER] &&
      req_client != hbta_pkg::HBTA_CL_MSI |=> !req_issue)
      else $error("memory request without master enable");
   // error handling checks
   perr_drop_a: assert property (@(posedge clk) disable iff (reset)
      in_valid && in_parity_err |=> perr_ff && !claim && !cpl_deliver)
      else $error("parity cycle not dropped");
   perr_serr_a: assert property (@(posedge clk) disable iff (reset)
      in_valid && in_parity_err && cmd_ff[`HBTA_CMD_PERR] |=> serr_pulse)
      else $error("parity system error missing");
   cpl_bad_a: assert property (@(posedge clk) disable iff (reset)
      cpl_bad |=> serr_ff && !cpl_deliver)
      else $error("bad completion mishandled");
   // identity and claim checks
   bus_latch_a: assert property (@(posedge clk) disable iff (reset)
      cfg_hit && in_kind == hbta_pkg::HBTA_IN_CFG_WR |=>
      my_id[15:8] == $past(in_cfg_bus))
      else $error("bus number not captured");
   cfg_claim_a: assert property (@(posedge clk) disable iff (reset)
      cfg_hit |=> claim && cpl_id[7:0] == 8'hc8)
      else $error("config cycle not claimed");
   // write-once check
   wonce_lock_a: assert property (@(posedge clk) disable iff (reset)
      wonce_lock_ff && reg_wr && reg_addr == `HBTA_OFF_WONCE |=>
      $stable(wonce_ff))
      else $error("write-once field changed");
   // completion routing
   cpl_route_a: assert property (@(posedge clk) disable iff (reset)
      in_good && in_kind == hbta_pkg::HBTA_IN_CPL &&
      in_cpl_status == `HBTA_CPL_OK |=>
      cpl_deliver && cpl_tag == $past(in_tag))
      else $error("completion not routed");
   // foreign config cycles
   cfg_other_a: assert property (@(posedge clk) disable iff (reset)
      in_valid && (in_kind == hbta_pkg::HBTA_IN_CFG_RD ||
      in_kind == hbta_pkg::HBTA_IN_CFG_WR) && (!in_cfg_type0 ||
      in_cfg_dev != `HBTA_DEV_NUM || in_cfg_func != `HBTA_FUNC_NUM) |=>
      !claim)
      else $error("foreign config cycle claimed");
   // sticky bits across resets
   stk_hold_a: assert property (@(posedge clk)
      reset && !main_power_good_reset && !reg_wr |=>
      $stable(sticky_ff) || main_power_good_reset)
      else $error("sticky bits lost on reset");
   stk_aux_a: assert property (@(posedge clk)
      aux_power_enabled && !reg_wr |=> $stable(sticky_ff))
      else $error("sticky bits lost under aux power");
   // main scenarios
   cov_cfg_wr_c: cover property (@(posedge clk) disable iff (reset)
      cfg_hit && in_kind == hbta_pkg::HBTA_IN_CFG_WR);
   cov_mem_c: cover property (@(posedge clk) disable iff (reset) mem_hit);
   cov_bad_cpl_c: cover property (@(posedge clk) disable iff (reset) cpl_bad);
   cov_txdata_c: cover property (@(posedge clk) disable iff (reset)
      req_issue && req_tag == 8'h0b);
   cov_stk_c: cover property (@(posedge clk)
      aux_power_enabled && main_power_good_reset);
endmodule

/* shared/hbta_defs.svh */
// constants for the host bus transaction attribute block
`ifndef HBTA_DEFS_SVH
`define HBTA_DEFS_SVH
// register offsets of the plain register port (byte addresses)
`define HBTA_OFF_CMD      8'h00
`define HBTA_OFF_STAT     8'h04
`define HBTA_OFF_ID       8'h08
`define HBTA_OFF_BAR_MEM  8'h0c
`define HBTA_OFF_BAR_IO   8'h10
`define HBTA_OFF_STICKY   8'h14
`define HBTA_OFF_STKSTAT  8'h18
`define HBTA_OFF_WONCE    8'h1c
// command register bit positions
`define HBTA_CMD_IO       0
`define HBTA_CMD_MEM      1
`define HBTA_CMD_MASTER   2
`define HBTA_CMD_PERR     6
`define HBTA_CMD_SERR     8
// status register bit positions
`define HBTA_ST_SERR      14
`define HBTA_ST_PERR      15
// fixed identity and good completion status
`define HBTA_DEV_NUM      5'h19
`define HBTA_FUNC_NUM     3'h0
`define HBTA_CPL_OK       3'h0
// tag codes per client
`define HBTA_TAG_RX_DATA  8'h00
`define HBTA_TAG_RX_DRD0  8'h01
`define HBTA_TAG_RX_DWB0  8'h02
`define HBTA_TAG_TX_DRD0  8'h04
`define HBTA_TAG_TX_DWB0  8'h05
`define HBTA_TAG_TX_DRD1  8'h06
`define HBTA_TAG_TX_DWB1  8'h07
`define HBTA_TAG_TX_DAT0  8'h08
`define HBTA_TAG_RX_DRD1  8'h0c
`define HBTA_TAG_RX_DWB1  8'h0e
`define HBTA_TAG_MNG_RD   8'h10
`define HBTA_TAG_MNG_WR   8'h11
`define HBTA_TAG_MSI      8'h1e
// reset values
`define HBTA_STICKY_RST   16'h0000
`define HBTA_WONCE_RST    16'h0000
`endif

/* shared/hbta_pkg.sv */
// types for the host bus transaction attribute block
package hbta_pkg;
   // requesting internal clients
   typedef enum logic [3:0] {
      HBTA_CL_RX_DATA = 4'h0,
      HBTA_CL_RX_DRD0 = 4'h1,
      HBTA_CL_RX_DWB0 = 4'h2,
      HBTA_CL_TX_DRD0 = 4'h3,
      HBTA_CL_TX_DWB0 = 4'h4,
      HBTA_CL_TX_DRD1 = 4'h5,
      HBTA_CL_TX_DWB1 = 4'h6,
      HBTA_CL_TX_DATA = 4'h7,
      HBTA_CL_RX_DRD1 = 4'h8,
      HBTA_CL_RX_DWB1 = 4'h9,
      HBTA_CL_MNG_RD  = 4'ha,
      HBTA_CL_MNG_WR  = 4'hb,
      HBTA_CL_MSI     = 4'hc
   } hbta_client_type;
   // incoming cycle kinds
   typedef enum logic [2:0] {
      HBTA_IN_CFG_RD = 3'h0,
      HBTA_IN_CFG_WR = 3'h1,
      HBTA_IN_MEM_RD = 3'h2,
      HBTA_IN_MEM_WR = 3'h3,
      HBTA_IN_IO_RD  = 3'h4,
      HBTA_IN_IO_WR  = 3'h5,
      HBTA_IN_CPL    = 3'h6
   } hbta_in_kind_type;
endpackage

/* test/hbta_host_model.sv */
// host side model: issues incoming cycles, answers requests
`timescale 1ns/100ps
module hbta_host_model (
   input  wire logic              clk,           // host bus clock
   input  wire logic              req_issue,     // request leaving core
   input  wire logic [7:0]        req_tag,       // its header tag
   output logic                   in_valid,      // cycle strobe
   output hbta_pkg::hbta_in_kind_type in_kind,   // cycle kind
   output logic                   in_parity_err, // forwarded parity
   output logic [31:0]            in_addr,       // address
   output logic [7:0]             in_cfg_bus,    // cfg bus number
   output logic [4:0]             in_cfg_dev,    // cfg device
   output logic [2:0]             in_cfg_func,   // cfg function
   output logic                   in_cfg_type0,  // cfg type 0
   output logic [7:0]             in_tag,        // completion tag
   output logic [2:0]             in_cpl_status  // completion status
);
   logic [7:0] tag_q [$]; // outstanding tags, oldest first
   logic       t0_next = 1'b1; // type 0 flag of later cycles
   logic [2:0] fn_next = 3'h0; // function number of later cycles
   // quiet bus at start
   initial begin
      {in_valid, in_parity_err, in_addr, in_cfg_bus} = '0;
      {in_cfg_dev, in_cfg_func, in_tag, in_cpl_status} = '0;
      in_cfg_type0 = 1'b1;
      in_kind = hbta_pkg::HBTA_IN_CFG_RD;
   end
   // remember tags of issued requests
   always @(posedge clk) if (req_issue === 1'b1) tag_q.push_back(req_tag);
   // one cycle on the bus, then scramble released lines
   task automatic send(input logic [2:0] k, input logic [31:0] a,
      input logic [7:0] b, input logic [4:0] d, input logic p,
      input logic [2:0] s, input logic [7:0] t);
      @(posedge clk);
      in_valid <= 1'b1;
      in_kind <= hbta_pkg::hbta_in_kind_type'(k);
      in_addr <= a;
      in_cfg_bus <= b;
      in_cfg_dev <= d;
      in_cfg_func <= fn_next;
      in_cfg_type0 <= t0_next;
      in_parity_err <= p;
      in_cpl_status <= s;
      in_tag <= t;
      @(posedge clk);
      in_valid <= 1'b0;
      in_addr <= ~a;
      in_cfg_bus <= ~b;
      in_tag <= ~t;
      in_cpl_status <= ~s;
      in_parity_err <= ~p;
   endtask
   // completion for the oldest request, after a delay
   task automatic answer(input int dly, input logic [2:0] s);
      repeat (dly) @(posedge clk);
      send(3'h6, 32'h0, 8'h0, 5'h0, 1'b0, s, tag_q.pop_front());
   endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the transaction attribute core
`timescale 1ns/100ps
`include "hbta_defs.svh"
module testbench;
   logic clk = 1'b0, reset = 1'b1, mpg = 1'b1, aux = 1'b1, aux_en = 1'b0;
   logic [7:0] reg_addr = 8'h00;       // register address
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d; // register data
   logic reg_wr = 1'b0, reg_rd = 1'b0; // register strobes
   logic req_valid = 1'b0;             // client request
   hbta_pkg::hbta_client_type req_client = hbta_pkg::HBTA_CL_RX_DATA;
   logic [1:0] req_slot = 2'h0;        // tx data slot
   logic req_issue, claim, cpl_deliver, serr_pulse, in_valid, in_perr;
   logic [7:0] req_tag, cpl_tag, in_bus, in_tag;
   logic [15:0] req_id, cpl_id;        // identifiers
   hbta_pkg::hbta_in_kind_type in_kind;
   logic [31:0] in_addr;
   logic [4:0] in_dev;
   logic [2:0] in_func, in_st;
   logic in_t0;
   int bad_count = 0, cmp_count = 0, n_issue = 0;
   logic [7:0] tg [13] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h0c, 8'h0e, 8'h10, 8'h11, 8'h1e}; // tag per client code
   always #5 clk = ~clk;
   // count issued requests to spot reissues
   always @(posedge clk) if (req_issue === 1'b1) n_issue++;
   hbta_core #(.BAR_MASK_BITS(12)) i_dut (.clk(clk), .reset(reset),
      .main_power_good_reset(mpg), .aux_power_ok_reset(aux),
      .aux_power_enabled(aux_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .req_valid(req_valid),
      .req_client(req_client), .req_slot(req_slot),
      .req_issue(req_issue), .req_tag(req_tag), .req_id(req_id),
      .in_valid(in_valid), .in_kind(in_kind), .in_parity_err(in_perr),
      .in_addr(in_addr), .in_cfg_bus(in_bus), .in_cfg_dev(in_dev),
      .in_cfg_func(in_func), .in_cfg_type0(in_t0), .in_tag(in_tag),
      .in_cpl_status(in_st), .claim(claim), .cpl_id(cpl_id),
      .cpl_deliver(cpl_deliver), .cpl_tag(cpl_tag),
      .serr_pulse(serr_pulse));
   hbta_host_model i_host (.clk(clk), .req_issue(req_issue),
      .req_tag(req_tag), .in_valid(in_valid), .in_kind(in_kind),
      .in_parity_err(in_perr), .in_addr(in_addr), .in_cfg_bus(in_bus),
      .in_cfg_dev(in_dev), .in_cfg_func(in_func), .in_cfg_type0(in_t0),
      .in_tag(in_tag), .in_cpl_status(in_st));
   // compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t mismatch seen %h exp %h", $time, s, e);
      end
   endtask
   // verdict and stop
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one write cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read, compare data of the following cycle
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // one client request, outputs settled on return
   task automatic req(input logic [3:0] c, input logic [1:0] s);
      @(posedge clk);
      req_valid <= 1'b1;
      req_client <= hbta_pkg::hbta_client_type'(c);
      req_slot <= s;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
   endtask
   // incoming cycle, outputs settled on return
   task automatic cyc(input logic [2:0] k, input logic [31:0] a,
      input logic [7:0] b, input logic [4:0] dv, input logic p);
      i_host.send(k, a, b, dv, p, 3'h0, 8'h00);
      #1;
   endtask
   // pulse chosen resets {ordinary, power good, aux ok}
   task automatic rst(input logic [2:0] w);
      @(posedge clk);
      {reset, mpg, aux} <= w;
      @(posedge clk);
      {reset, mpg, aux} <= 3'h0;
   endtask
   // reset values, read-only mask, unmapped, write-once
   task automatic t_regs;
      rdc(`HBTA_OFF_CMD, 32'h0);
      rdc(`HBTA_OFF_STAT, 32'h10);
      rdc(8'h40, 32'h0);
      wr(`HBTA_OFF_ID, 32'hffffffff);
      rdc(`HBTA_OFF_ID, 32'hc8);
      wr(`HBTA_OFF_CMD, 32'hffffffff);
      rdc(`HBTA_OFF_CMD, 32'h547);
      wr(`HBTA_OFF_WONCE, 32'h1234);
      wr(`HBTA_OFF_WONCE, 32'h5678);
      rdc(`HBTA_OFF_WONCE, 32'h1234);
      $display("regs done");
   endtask
   // every client code and every data slot
   task automatic t_tags;
      wr(`HBTA_OFF_CMD, 32'h4);
      for (int i = 0; i < 13; i++) begin
         req(i[3:0], 2'h0);
         chk(req_issue, 1'b1);
         chk(req_tag, tg[i]);
      end
      for (int s = 0; s < 4; s++) begin
         req(4'h7, s[1:0]);
         chk(req_tag, 8'h08 + s);
      end
      chk(req_id, 16'h00c8);
      i_host.tag_q.delete();
      wr(`HBTA_OFF_CMD, 32'h0);
      req(4'h0, 2'h0);
      chk(req_issue, 1'b0);
      req(4'ha, 2'h0);
      chk(req_issue, 1'b0);
      req(4'hc, 2'h0);
      chk(req_issue, 1'b1);
      chk(req_tag, 8'h1e);
      $display("tags done");
   endtask
   // config claim, bus capture, windows
   task automatic t_claim;
      logic [2:0] k [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
      logic [31:0] a [4] = '{32'h10000ffc, 32'h10001000, 32'h2004, 32'h3000};
      wr(`HBTA_OFF_CMD, 32'h7);
      cyc(3'h1, 32'h0, 8'h5a, 5'h19, 1'b0);
      chk(claim, 1'b1);
      chk(cpl_id, 16'h5ac8);
      cyc(3'h1, 32'h0, 8'h33, 5'h18, 1'b0);
      chk(claim, 1'b0);
      i_host.t0_next = 1'b0;
      cyc(3'h0, 32'h0, 8'h00, 5'h19, 1'b0);
      chk(claim, 1'b0);
      i_host.t0_next = 1'b1;
      i_host.fn_next = 3'h1;
      cyc(3'h0, 32'h0, 8'h00, 5'h19, 1'b0);
      chk(claim, 1'b0);
      i_host.fn_next = 3'h0;
      req(4'hc, 2'h0);
      chk(req_id, 16'h5ac8);
      wr(`HBTA_OFF_BAR_MEM, 32'h10000000);
      wr(`HBTA_OFF_BAR_IO, 32'h2000);
      for (int i = 0; i < 4; i++) begin
         cyc(k[i], a[i], 8'h00, 5'h00, 1'b0);
         chk(claim, i % 2 == 0);
      end
      $display("claim done");
   endtask
   // parity drop, flags, w1c and sticky status
   task automatic t_perr;
      wr(`HBTA_OFF_CMD, 32'h47);
      cyc(3'h1, 32'h0, 8'h77, 5'h19, 1'b1);
      chk(claim, 1'b0);
      chk(serr_pulse, 1'b1);
      req(4'hc, 2'h0);
      chk(req_id, 16'h5ac8);
      rdc(`HBTA_OFF_STAT, 32'h8010);
      wr(`HBTA_OFF_STAT, 32'h0);
      rdc(`HBTA_OFF_STAT, 32'h8010);
      wr(`HBTA_OFF_STAT, 32'h8000);
      rdc(`HBTA_OFF_STAT, 32'h10);
      wr(`HBTA_OFF_CMD, 32'h7);
      cyc(3'h2, 32'h10000000, 8'h00, 5'h00, 1'b1);
      chk(serr_pulse, 1'b0);
      rdc(`HBTA_OFF_STKSTAT, 32'h1);
      rst(3'h4);
      rdc(`HBTA_OFF_STKSTAT, 32'h1);
      rst(3'h1);
      rdc(`HBTA_OFF_STKSTAT, 32'h0);
      $display("parity done");
   endtask
   // slow good completion, bad ones dropped and never reissued
   task automatic t_cpl;
      int n;
      wr(`HBTA_OFF_CMD, 32'h104);
      i_host.tag_q.delete();
      req(4'h3, 2'h0);
      req(4'h3, 2'h0);
      @(posedge clk);
      #1 n = n_issue;
      i_host.answer(200, 3'h0);
      #1 chk(cpl_deliver, 1'b1);
      chk(cpl_tag, 8'h04);
      i_host.answer(0, 3'h1);
      #1 chk(cpl_deliver, 1'b0);
      chk(serr_pulse, 1'b1);
      rdc(`HBTA_OFF_STAT, 32'h4010);
      repeat (20) @(posedge clk);
      chk(n_issue, n);
      wr(`HBTA_OFF_CMD, 32'h4);
      req(4'h1, 2'h0);
      i_host.answer(3, 3'h2);
      #1 chk(serr_pulse, 1'b0);
      $display("completion done");
   endtask
   // sticky read/write survives ordinary reset
   task automatic t_sticky;
      aux_en <= 1'b1;
      wr(`HBTA_OFF_STICKY, 32'ha5a5);
      rst(3'h4);
      rdc(`HBTA_OFF_STICKY, 32'ha5a5);
      rst(3'h2);
      rdc(`HBTA_OFF_STICKY, 32'ha5a5);
      @(posedge clk) aux_en <= 1'b0;
      rst(3'h2);
      rdc(`HBTA_OFF_STICKY, 32'h0);
      $display("sticky done");
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      {reset, mpg, aux} <= 3'h0;
      t_regs();
      t_tags();
      t_claim();
      t_perr();
      t_cpl();
      t_sticky();
      end_sim();
   end
endmodule
